// [hdl/rtc_regs.svh]
`ifndef RTC_REGS_SVH
`define RTC_REGS_SVH

// timing
`define RTC_CLK_PERIOD_NS 10
`define RTC_SEC_PERIOD_MS 1000
`define RTC_PER_PERIOD_MS 500
`define RTC_UPD_LEAD_US 244
`define RTC_PWRUP_MS 200
`define RTC_SEC_CYCLES ((`RTC_SEC_PERIOD_MS * 1000000) / `RTC_CLK_PERIOD_NS)
`define RTC_PER_CYCLES ((`RTC_PER_PERIOD_MS * 1000000) / `RTC_CLK_PERIOD_NS)
`define RTC_UPD_LEAD_CYCLES ((`RTC_UPD_LEAD_US * 1000 + `RTC_CLK_PERIOD_NS - 1) / `RTC_CLK_PERIOD_NS)
`define RTC_PWRUP_CYCLES ((`RTC_PWRUP_MS * 1000000 + `RTC_CLK_PERIOD_NS - 1) / `RTC_CLK_PERIOD_NS)

// structure
`define RTC_SYNC_DEPTH 3
`define RTC_ADDR_W 7
`define RTC_MAP_BYTES 128
`define RTC_TIME_BYTES 10
`define RTC_RAM_FIRST 14

// byte offsets
`define RTC_OFS_SEC 7'h00
`define RTC_OFS_SEC_ALM 7'h01
`define RTC_OFS_MIN 7'h02
`define RTC_OFS_MIN_ALM 7'h03
`define RTC_OFS_HOUR 7'h04
`define RTC_OFS_HOUR_ALM 7'h05
`define RTC_OFS_WDAY 7'h06
`define RTC_OFS_MDAY 7'h07
`define RTC_OFS_MONTH 7'h08
`define RTC_OFS_YEAR 7'h09
`define RTC_OFS_REG_A 7'h0A
`define RTC_OFS_REG_B 7'h0B
`define RTC_OFS_REG_C 7'h0C
`define RTC_OFS_REG_D 7'h0D

// register fields
`define RTC_A_UPD_PEND 7
`define RTC_B_FREEZE 7
`define RTC_B_PER_EN 6
`define RTC_B_ALM_EN 5
`define RTC_B_UPD_EN 4
`define RTC_B_WAVE_EN 3
`define RTC_B_FMT_BIN 2
`define RTC_B_HOUR24 1
`define RTC_C_SUMMARY 7
`define RTC_FLG_UPD 0
`define RTC_FLG_ALM 1
`define RTC_FLG_PER 2
`define RTC_REG_D_VAL 8'h80
`define RTC_SEC_RO_BIT 7
`define RTC_PM_BIT 7
`define RTC_ALM_DONT_CARE 2'h3

// value limits, binary
`define RTC_SEC_MAX 7'h3B
`define RTC_MIN_MAX 7'h3B
`define RTC_HOUR24_MAX 7'h17
`define RTC_HOUR12_MAX 7'h0C
`define RTC_WDAY_MAX 7'h07
`define RTC_MONTH_MAX 7'h0C
`define RTC_YEAR_MAX 7'h63

`endif

// [hdl/rtc_pkg.sv]
`include "rtc_regs.svh"

package rtc_pkg;
  typedef logic [7:0] rtc_byte_t;

  typedef enum logic [2:0] {
    BP_IDLE = 3'b001,
    BP_READ = 3'b010,
    BP_WRITE = 3'b100
  } rtc_phase_e;

  typedef struct packed {
    logic [`RTC_SYNC_DEPTH-1:0] adrSync;
    logic [`RTC_SYNC_DEPTH-1:0] dstbSync;
    logic [`RTC_SYNC_DEPTH-1:0] rwSync;
    logic [`RTC_SYNC_DEPTH-1:0] csnSync;
    logic [`RTC_SYNC_DEPTH-1:0] rstSync;
    logic [`RTC_SYNC_DEPTH-1:0][7:0] busSync;
    logic adrLvl;
    logic dstbLvl;
    logic rwLvl;
    logic csnLvl;
    logic rstLvl;
    logic [`RTC_ADDR_W-1:0] addr;
    logic addrValid;
    rtc_phase_e phase;
    rtc_byte_t rdData;
    logic adOe;
    logic [6:0] regA;
    rtc_byte_t regB;
    logic [2:0] flags;
    logic [2:0] pend;
    logic [`RTC_TIME_BYTES-1:0][7:0] tmInt;
    logic [`RTC_MAP_BYTES-1:0][7:0] mem;
    logic [31:0] secCnt;
    logic [31:0] perCnt;
    logic [31:0] pwrCnt;
    logic pwrDone;
    logic waveLvl;
    logic irqOe;
  } rtc_state_s;
endpackage

// [hdl/rtc_core.sv]
`include "rtc_regs.svh"

module rtc_core #(
  parameter int SEC_CYCLES = `RTC_SEC_CYCLES,
  parameter int PER_CYCLES = `RTC_PER_CYCLES,
  parameter int UPD_LEAD_CYCLES = `RTC_UPD_LEAD_CYCLES,
  parameter int PWRUP_CYCLES = `RTC_PWRUP_CYCLES
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic addressStrobe,
  input wire logic dataStrobe,
  input wire logic readNotWrite,
  input wire logic chipSelectN,
  input wire logic resetPinN,
  input wire rtc_pkg::rtc_byte_t adIn,
  output rtc_pkg::rtc_byte_t adOut,
  output logic adOe,
  output logic irqOut,
  output logic irqOe,
  output logic squareWaveOut
);
  import rtc_pkg::*;

  if (SEC_CYCLES < 2 || PER_CYCLES < 2 || PWRUP_CYCLES < 1 || UPD_LEAD_CYCLES < 1 ||
      UPD_LEAD_CYCLES >= SEC_CYCLES) begin : g_bad_params
    $error("rtc_core: timing parameters out of range");
  end

  rtc_state_s st_q;
  rtc_state_s st_d;

  function automatic logic settle(input logic [`RTC_SYNC_DEPTH-1:0] sy, input logic cur);
    return (sy[1] == sy[2]) ? sy[2] : cur;
  endfunction

  function automatic logic [6:0] fromFmt(input rtc_byte_t v, input logic bin);
    if (bin) begin
      return v[6:0];
    end
    return 7'(v[7:4]) * 7'h0A + 7'(v[3:0]);
  endfunction

  function automatic rtc_byte_t toFmt(input logic [6:0] v, input logic bin);
    logic [6:0] tens;
    tens = v / 7'h0A;
    if (bin) begin
      return {1'b0, v};
    end
    return {tens[3:0], 4'(v - tens * 7'h0A)};
  endfunction

  function automatic logic [6:0] monthDays(input logic [6:0] mon, input logic [6:0] yr);
    unique case (mon)
      7'h02: return (yr[1:0] == 2'h0) ? 7'h1D : 7'h1C;
      7'h04, 7'h06, 7'h09, 7'h0B: return 7'h1E;
      default: return 7'h1F;
    endcase
  endfunction

  function automatic logic almHit(input rtc_byte_t alm, input rtc_byte_t cnt);
    return (alm[7:6] == `RTC_ALM_DONT_CARE) || (alm == cnt);
  endfunction

  // binary arithmetic on decoded fields keeps one path for both formats
  function automatic logic [`RTC_TIME_BYTES-1:0][7:0] advance(
    input logic [`RTC_TIME_BYTES-1:0][7:0] t,
    input logic bin,
    input logic h24
  );
    logic [6:0] sec;
    logic [6:0] mnt;
    logic [6:0] hr;
    logic [6:0] wday;
    logic [6:0] day;
    logic [6:0] mon;
    logic [6:0] yr;
    logic pm;
    logic dayStep;
    logic [`RTC_TIME_BYTES-1:0][7:0] r;
    r = t;
    sec = fromFmt(t[`RTC_OFS_SEC], bin);
    mnt = fromFmt(t[`RTC_OFS_MIN], bin);
    hr = fromFmt({1'b0, t[`RTC_OFS_HOUR][6:0]}, bin);
    wday = fromFmt(t[`RTC_OFS_WDAY], bin);
    day = fromFmt(t[`RTC_OFS_MDAY], bin);
    mon = fromFmt(t[`RTC_OFS_MONTH], bin);
    yr = fromFmt(t[`RTC_OFS_YEAR], bin);
    pm = !h24 && t[`RTC_OFS_HOUR][`RTC_PM_BIT];
    dayStep = 1'b0;
    if (sec < `RTC_SEC_MAX) begin
      sec = sec + 7'h01;
    end else begin
      sec = 7'h00;
      if (mnt < `RTC_MIN_MAX) begin
        mnt = mnt + 7'h01;
      end else begin
        mnt = 7'h00;
        if (h24) begin
          dayStep = (hr >= `RTC_HOUR24_MAX);
          hr = dayStep ? 7'h00 : hr + 7'h01;
        end else if (hr >= `RTC_HOUR12_MAX) begin
          hr = 7'h01;
        end else begin
          hr = hr + 7'h01;
          if (hr == `RTC_HOUR12_MAX) begin
            dayStep = pm;
            pm = !pm;
          end
        end
      end
    end
    if (dayStep) begin
      wday = (wday >= `RTC_WDAY_MAX) ? 7'h01 : wday + 7'h01;
      if (day >= monthDays(mon, yr)) begin
        day = 7'h01;
        if (mon >= `RTC_MONTH_MAX) begin
          mon = 7'h01;
          yr = (yr >= `RTC_YEAR_MAX) ? 7'h00 : yr + 7'h01;
        end else begin
          mon = mon + 7'h01;
        end
      end else begin
        day = day + 7'h01;
      end
    end
    r[`RTC_OFS_SEC] = toFmt(sec, bin);
    r[`RTC_OFS_MIN] = toFmt(mnt, bin);
    r[`RTC_OFS_HOUR] = toFmt(hr, bin) | {pm, 7'h00};
    r[`RTC_OFS_WDAY] = toFmt(wday, bin);
    r[`RTC_OFS_MDAY] = toFmt(day, bin);
    r[`RTC_OFS_MONTH] = toFmt(mon, bin);
    r[`RTC_OFS_YEAR] = toFmt(yr, bin);
    return r;
  endfunction

  function automatic logic isAlarmByte(input int i);
    return i == int'(`RTC_OFS_SEC_ALM) || i == int'(`RTC_OFS_MIN_ALM) || i == int'(`RTC_OFS_HOUR_ALM);
  endfunction

  always_comb begin
    logic adrNew;
    logic dstbNew;
    logic accessOk;
    logic secTick;
    logic perTick;
    logic dstbFall;
    logic clearC;
    logic holdC;
    logic freeze;
    logic updPend;
    logic [2:0] ev;
    logic [`RTC_TIME_BYTES-1:0][7:0] adv;
    rtc_byte_t wd;
    logic [`RTC_ADDR_W-1:0] a;
    st_d = st_q;
    adrNew = settle(st_q.adrSync, st_q.adrLvl);
    dstbNew = settle(st_q.dstbSync, st_q.dstbLvl);
    accessOk = 1'b0;
    secTick = 1'b0;
    perTick = 1'b0;
    dstbFall = 1'b0;
    clearC = 1'b0;
    holdC = 1'b0;
    freeze = st_q.regB[`RTC_B_FREEZE];
    updPend = 1'b0;
    ev = 3'h0;
    adv = st_q.tmInt;
    wd = st_q.busSync[2];
    a = st_q.addr;

    // three-stage pin synchronisers
    st_d.adrSync = {st_q.adrSync[1:0], addressStrobe};
    st_d.dstbSync = {st_q.dstbSync[1:0], dataStrobe};
    st_d.rwSync = {st_q.rwSync[1:0], readNotWrite};
    st_d.csnSync = {st_q.csnSync[1:0], chipSelectN};
    st_d.rstSync = {st_q.rstSync[1:0], resetPinN};
    st_d.busSync = {st_q.busSync[1:0], adIn};
    st_d.adrLvl = adrNew;
    st_d.dstbLvl = dstbNew;
    st_d.rwLvl = settle(st_q.rwSync, st_q.rwLvl);
    st_d.csnLvl = settle(st_q.csnSync, st_q.csnLvl);
    st_d.rstLvl = settle(st_q.rstSync, st_q.rstLvl);

    // power-up lockout
    if (!st_q.pwrDone) begin
      if (st_q.pwrCnt >= 32'(PWRUP_CYCLES - 1)) begin
        st_d.pwrDone = 1'b1;
      end else begin
        st_d.pwrCnt = st_q.pwrCnt + 32'h1;
      end
    end

    // time base; free-running so the reset pin cannot disturb it
    secTick = st_q.secCnt >= 32'(SEC_CYCLES - 1);
    st_d.secCnt = secTick ? 32'h0 : st_q.secCnt + 32'h1;
    updPend = !freeze && st_q.secCnt >= 32'(SEC_CYCLES - UPD_LEAD_CYCLES);
    perTick = st_q.perCnt >= 32'(PER_CYCLES - 1);
    st_d.perCnt = perTick ? 32'h0 : st_q.perCnt + 32'h1;
    if (perTick && st_q.regA[3:0] != 4'h0) begin
      ev[`RTC_FLG_PER] = 1'b1;
      st_d.waveLvl = !st_q.waveLvl;
    end
    if (!st_q.regB[`RTC_B_WAVE_EN]) begin
      st_d.waveLvl = 1'b0;
    end

    // internal copy always counts; host copy follows only when not frozen
    if (secTick) begin
      adv = advance(st_q.tmInt, st_q.regB[`RTC_B_FMT_BIN], st_q.regB[`RTC_B_HOUR24]);
      st_d.tmInt = adv;
      if (!freeze) begin
        for (int i = 0; i < `RTC_TIME_BYTES; i++) begin
          if (!isAlarmByte(i)) begin
            st_d.mem[i] = adv[i];
          end
        end
        ev[`RTC_FLG_UPD] = 1'b1;
      end
      if (almHit(st_q.mem[`RTC_OFS_SEC_ALM], adv[`RTC_OFS_SEC]) &&
          almHit(st_q.mem[`RTC_OFS_MIN_ALM], adv[`RTC_OFS_MIN]) &&
          almHit(st_q.mem[`RTC_OFS_HOUR_ALM], adv[`RTC_OFS_HOUR])) begin
        ev[`RTC_FLG_ALM] = 1'b1;
      end
    end

    // address phase: rising strobe drops the address, falling latches it
    if (adrNew && !st_q.adrLvl) begin
      st_d.addrValid = 1'b0;
    end
    if (!adrNew && st_q.adrLvl) begin
      st_d.addr = st_q.busSync[2][`RTC_ADDR_W-1:0];
      st_d.addrValid = 1'b1;
    end

    accessOk = !st_q.csnLvl && st_q.rstLvl && st_q.pwrDone && st_q.addrValid;
    if (dstbNew && !st_q.dstbLvl && accessOk) begin
      if (st_q.rwLvl) begin
        st_d.phase = BP_READ;
        st_d.adOe = 1'b1;
        unique case (a)
          `RTC_OFS_REG_A: st_d.rdData = {updPend, st_q.regA};
          `RTC_OFS_REG_B: st_d.rdData = st_q.regB;
          `RTC_OFS_REG_C: st_d.rdData = {st_q.irqOe, st_q.flags, 4'h0};
          `RTC_OFS_REG_D: st_d.rdData = `RTC_REG_D_VAL;
          default: st_d.rdData = st_q.mem[a];
        endcase
      end else begin
        st_d.phase = BP_WRITE;
      end
    end

    // data latched on the trailing strobe edge
    dstbFall = !dstbNew && st_q.dstbLvl;
    if (dstbFall) begin
      unique case (st_q.phase)
        BP_READ: clearC = a == `RTC_OFS_REG_C;
        BP_WRITE: begin
          if (accessOk) begin
            unique case (a)
              `RTC_OFS_REG_A: st_d.regA = wd[6:0];
              `RTC_OFS_REG_B: begin
                st_d.regB = wd;
                if (wd[`RTC_B_FREEZE]) begin
                  st_d.regB[`RTC_B_UPD_EN] = 1'b0;
                end else if (freeze) begin
                  st_d.tmInt = st_q.mem[`RTC_TIME_BYTES-1:0];
                end
              end
              `RTC_OFS_REG_C, `RTC_OFS_REG_D: ;
              default: begin
                st_d.mem[a] = wd;
                if (a == `RTC_OFS_SEC) begin
                  st_d.mem[a][`RTC_SEC_RO_BIT] = 1'b0;
                end
                if (a < `RTC_ADDR_W'(`RTC_TIME_BYTES) && !freeze) begin
                  st_d.tmInt[a[3:0]] = st_d.mem[a];
                end
              end
            endcase
          end
        end
        BP_IDLE: ;
      endcase
      st_d.phase = BP_IDLE;
      st_d.adOe = 1'b0;
    end

    // flags: events during a C read wait; a new event beats the clear
    holdC = st_q.phase == BP_READ && a == `RTC_OFS_REG_C;
    if (clearC) begin
      st_d.flags = st_q.pend | ev;
      st_d.pend = 3'h0;
    end else if (holdC) begin
      st_d.pend = st_q.pend | ev;
    end else begin
      st_d.flags = st_q.flags | ev;
    end

    if (!st_q.rstLvl) begin
      st_d.regB[`RTC_B_PER_EN] = 1'b0;
      st_d.regB[`RTC_B_ALM_EN] = 1'b0;
      st_d.regB[`RTC_B_UPD_EN] = 1'b0;
      st_d.regB[`RTC_B_WAVE_EN] = 1'b0;
      st_d.flags = 3'h0;
      st_d.pend = 3'h0;
      st_d.phase = BP_IDLE;
      st_d.adOe = 1'b0;
    end

    st_d.irqOe = |(st_d.flags & st_d.regB[`RTC_B_PER_EN:`RTC_B_UPD_EN]);
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_q <= '0;
      st_q.phase <= BP_IDLE;
    end else begin
      st_q <= st_d;
    end
  end

  assign adOut = st_q.rdData;
  assign adOe = st_q.adOe;
  assign irqOut = 1'b0;
  assign irqOe = st_q.irqOe;
  assign squareWaveOut = st_q.waveLvl;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);

  sequence sReadCEnd;
    st_q.phase == BP_READ && st_q.addr == `RTC_OFS_REG_C && st_q.dstbLvl && !st_d.dstbLvl && st_q.rstLvl;
  endsequence

  sequence sWriteB;
    st_q.phase == BP_WRITE && st_q.addr == `RTC_OFS_REG_B && st_q.dstbLvl && !st_d.dstbLvl &&
      !st_q.csnLvl && st_q.addrValid && st_q.rstLvl && st_q.pwrDone;
  endsequence

  a_irq_follow: assert property (st_q.irqOe == |(st_q.flags & st_q.regB[6:4]))
    else $error("interrupt output does not follow flags and enables");
  a_irq_float: assert property (!(|(st_q.flags & st_q.regB[6:4])) |-> !irqOe)
    else $error("interrupt driven with nothing pending");
  a_pin_reset: assert property (!st_q.rstLvl |=> st_q.flags == 3'h0 && st_q.regB[6:3] == 4'h0 && !irqOe)
    else $error("reset pin did not clear enables and flags");
  a_pend_reset: assert property (!st_q.rstLvl |=> st_q.pend == 3'h0)
    else $error("deferred events survived reset pin");
  a_ram_kept: assert property (!st_q.rstLvl |=> $stable(st_q.mem[`RTC_MAP_BYTES-1:`RTC_RAM_FIRST]))
    else $error("user RAM changed under reset pin");
  a_no_access: assert property (!st_q.rstLvl ##1 !st_q.rstLvl |-> !adOe && st_q.phase == BP_IDLE)
    else $error("bus access served during reset pin");
  a_sec_msb: assert property (!st_q.mem[`RTC_OFS_SEC][7])
    else $error("seconds top bit became set");
  a_freeze_uie: assert property (sWriteB ##0 st_q.busSync[2][7] |=> !st_q.regB[4] && st_q.regB[7])
    else $error("freeze did not clear update-ended enable");
  a_enable_now: assert property (sWriteB ##0 st_q.busSync[2][5] && st_q.flags[1] |=> irqOe)
    else $error("enable with set flag did not assert interrupt");
  a_read_clear: assert property (sReadCEnd ##0 st_q.secCnt != 32'h0 && st_q.perCnt != 32'h0 &&
      st_q.secCnt < 32'(SEC_CYCLES - 1) && st_q.perCnt < 32'(PER_CYCLES - 1)
      |=> st_q.flags == $past(st_q.pend) && st_q.pend == 3'h0)
    else $error("C read did not clear or post deferred events");
  a_read_stable: assert property (st_q.phase == BP_READ && st_q.addr == `RTC_OFS_REG_C && st_q.rstLvl &&
      st_d.dstbLvl |=> $stable(st_q.flags) && $stable(st_q.rdData))
    else $error("flags moved during C read");
  a_poll_flag: assert property (st_q.secCnt >= 32'(SEC_CYCLES - 1) && !st_q.regB[7] && st_q.rstLvl &&
      st_q.phase != BP_READ |=> st_q.flags[0])
    else $error("update flag not set by second tick");
  a_alarm_any: assert property (st_q.secCnt >= 32'(SEC_CYCLES - 1) && st_q.rstLvl && st_q.phase != BP_READ &&
      st_q.mem[1][7:6] == 2'h3 && st_q.mem[3][7:6] == 2'h3 && st_q.mem[5][7:6] == 2'h3
      |=> st_q.flags[1])
    else $error("don't-care alarm did not fire");
  a_addr_latch: assert property (st_q.adrLvl && !st_d.adrLvl |=> st_q.addrValid &&
      st_q.addr == $past(st_q.busSync[2][6:0]))
    else $error("address not latched on strobe fall");
endmodule

// [verification/rtc_host.sv]
module rtc_host (
  input wire logic clk,
  input wire rtc_pkg::rtc_byte_t adOut,
  input wire logic adOe,
  output logic addressStrobe,
  output logic dataStrobe,
  output logic readNotWrite,
  output logic chipSelectN,
  output rtc_pkg::rtc_byte_t hostData,
  output logic hostOe
);
  timeunit 1ns;
  timeprecision 100ps;
  import rtc_pkg::*;

  initial begin
    addressStrobe = 1'b0;
    dataStrobe = 1'b0;
    readNotWrite = 1'b1;
    chipSelectN = 1'b1;
    hostData = 8'h00;
    hostOe = 1'b0;
  end

  task automatic ticks(input int n);
    repeat (n) @(posedge clk);
  endtask

  // six cycles per level: the device filters every pin through three flops
  task automatic addrPhase(input logic [6:0] addr);
    @(posedge clk);
    chipSelectN <= 1'b0;
    hostOe <= 1'b1;
    hostData <= {1'b0, addr};
    addressStrobe <= 1'b1;
    ticks(6);
    addressStrobe <= 1'b0;
    ticks(6);
  endtask

  task automatic endCycle();
    hostOe <= 1'b0;
    chipSelectN <= 1'b1;
    readNotWrite <= 1'b1;
    ticks(4);
  endtask

  // direction set ahead: its filtered level lags a change made on the strobe edge
  task automatic busWrite(input logic [6:0] addr, input rtc_byte_t data);
    readNotWrite <= 1'b0;
    addrPhase(addr);
    hostData <= data;
    dataStrobe <= 1'b1;
    ticks(6);
    dataStrobe <= 1'b0;
    ticks(6);
    endCycle();
  endtask

  task automatic busRead(input logic [6:0] addr, output rtc_byte_t data);
    int n;
    addrPhase(addr);
    hostOe <= 1'b0;
    dataStrobe <= 1'b1;
    for (n = 0; n < 12 && adOe !== 1'b1; n++) ticks(1);
    ticks(2);
    data = (adOe === 1'b1) ? adOut : 8'hXX;
    dataStrobe <= 1'b0;
    for (n = 0; n < 12 && adOe !== 1'b0; n++) ticks(1);
    endCycle();
  endtask
endmodule

// [verification/rtc_calendar_alarm_interrupts_tb_top.sv]
`include "rtc_regs.svh"

module rtc_calendar_alarm_interrupts_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import rtc_pkg::*;

  localparam int SEC = 400;
  localparam int PER = 200;
  localparam logic [6:0] RB = `RTC_OFS_REG_B;
  localparam logic [6:0] RC = `RTC_OFS_REG_C;

  logic clk;
  logic resetn;
  logic resetPinN;
  logic addressStrobe;
  logic dataStrobe;
  logic readNotWrite;
  logic chipSelectN;
  logic hostOe;
  logic adOe;
  logic irqOut;
  logic irqOe;
  logic irqN;
  logic squareWaveOut;
  rtc_byte_t adIn;
  rtc_byte_t adOut;
  rtc_byte_t hostData;
  rtc_byte_t r;
  rtc_byte_t yr;
  rtc_byte_t bfmt;
  rtc_byte_t sec;
  rtc_byte_t mem [128];
  logic [6:0] ra [8];
  logic [7:0] floatPat = 8'h5A;
  logic [31:0] seed;
  int errCount;
  int compares;

  // released bus shows a toggling pattern, never a held value
  always @(posedge clk) floatPat <= ~floatPat;
  assign adIn = (adOe === 1'b1) ? adOut : (hostOe ? hostData : floatPat);
  assign irqN = (irqOe === 1'b1) ? irqOut : 1'b1;

  rtc_core #(.SEC_CYCLES(SEC), .PER_CYCLES(PER), .UPD_LEAD_CYCLES(4), .PWRUP_CYCLES(8)) dut (
    .clk(clk), .resetn(resetn), .addressStrobe(addressStrobe), .dataStrobe(dataStrobe),
    .readNotWrite(readNotWrite), .chipSelectN(chipSelectN), .resetPinN(resetPinN), .adIn(adIn),
    .adOut(adOut), .adOe(adOe), .irqOut(irqOut), .irqOe(irqOe), .squareWaveOut(squareWaveOut)
  );

  rtc_host host (
    .clk(clk), .adOut(adOut), .adOe(adOe), .addressStrobe(addressStrobe), .dataStrobe(dataStrobe),
    .readNotWrite(readNotWrite), .chipSelectN(chipSelectN), .hostData(hostData), .hostOe(hostOe)
  );

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  function automatic logic [31:0] xorshift(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction

  function automatic rtc_byte_t nextMin(input logic bin, input rtc_byte_t m);
    if (bin || m[3:0] != 4'h9) begin
      return m + 8'h01;
    end
    return {m[7:4] + 4'h1, 4'h0};
  endfunction

  task automatic chk(input rtc_byte_t got, input rtc_byte_t exp);
    compares++;
    if (got !== exp) begin
      errCount++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [6:0] a, input rtc_byte_t d);
    host.busWrite(a, d);
  endtask

  task automatic rd(input logic [6:0] a, output rtc_byte_t d);
    host.busRead(a, d);
  endtask

  task automatic waitIrqLow();
    int n;
    for (n = 0; n < SEC + 50 && irqN !== 1'b0; n++) @(posedge clk);
  endtask

  task automatic summarize();
    $display("compares=%0d mismatches=%0d", compares, errCount);
    if (errCount == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  initial begin
    #200000;
    errCount++;
    summarize();
  end

  initial begin
    resetn = 1'b0;
    resetPinN = 1'b0;
    errCount = 0;
    compares = 0;
    seed = 32'hC5782207;
    repeat (6) @(posedge clk);
    resetn <= 1'b1;
    repeat (30) @(posedge clk);
    resetPinN <= 1'b1;
    repeat (10) @(posedge clk);
    wr(RB, 8'h86);
    wr(`RTC_OFS_REG_A, 8'hA0);
    rd(`RTC_OFS_REG_A, r);
    chk(r, 8'h20);
    wr(`RTC_OFS_REG_D, 8'h00);
    rd(`RTC_OFS_REG_D, r);
    chk(r, `RTC_REG_D_VAL);
    $display("test read-only places done");
    for (int i = 0; i < 8; i++) begin
      seed = xorshift(seed);
      ra[i] = (i == 0) ? 7'h0E : (i == 1) ? 7'h7F : 7'(7'h0E + seed[6:0] % 7'd114);
      mem[ra[i]] = seed[15:8];
      wr(ra[i], seed[15:8]);
    end
    for (int i = 0; i < 8; i++) begin
      rd(ra[i], r);
      chk(r, mem[ra[i]]);
    end
    $display("test user ram done");
    for (int f = 0; f < 2; f++) begin
      bfmt = f ? 8'h06 : 8'h02;
      sec = f ? 8'h3B : 8'h59;
      wr(RB, 8'h90 | bfmt);
      rd(RB, r);
      chk(r, 8'h80 | bfmt);
      wr(`RTC_OFS_SEC, 8'h80 | sec);
      rd(`RTC_OFS_SEC, r);
      chk(r, sec);
      wr(`RTC_OFS_MIN, 8'h09);
      wr(RB, bfmt);
      repeat (SEC + 50) @(posedge clk);
      rd(`RTC_OFS_MIN, r);
      chk(r, nextMin(f[0], 8'h09));
    end
    $display("test time advance done");
    wr(`RTC_OFS_SEC_ALM, 8'hC0);
    wr(`RTC_OFS_MIN_ALM, 8'hFF);
    wr(`RTC_OFS_HOUR_ALM, 8'hC5);
    repeat (SEC + 50) @(posedge clk);
    rd(RC, r);
    chk(r, 8'h30);
    chk({7'h00, irqN}, 8'h01);
    repeat (SEC + 50) @(posedge clk);
    wr(RB, 8'h26);
    chk({7'h00, irqN}, 8'h00);
    rd(RC, r);
    chk(r, 8'hB0);
    waitIrqLow();
    rd(RC, r);
    chk(r, 8'hB0);
    chk({7'h00, irqN}, 8'h01);
    $display("test alarm interrupt done");
    wr(7'h40, 8'hA5);
    rd(`RTC_OFS_YEAR, yr);
    wr(`RTC_OFS_REG_A, 8'h2F);
    wr(RB, 8'h7E);
    sec = {7'h00, squareWaveOut};
    repeat (PER) @(posedge clk);
    chk({7'h00, squareWaveOut}, sec ^ 8'h01);
    waitIrqLow();
    @(posedge clk);
    resetPinN <= 1'b0;
    repeat (10) @(posedge clk);
    chk({7'h00, irqN}, 8'h01);
    chk({7'h00, squareWaveOut}, 8'h00);
    wr(7'h40, 8'h3C);
    @(posedge clk);
    resetPinN <= 1'b1;
    repeat (10) @(posedge clk);
    rd(7'h40, r);
    chk(r, 8'hA5);
    rd(RB, r);
    chk(r, 8'h06);
    rd(`RTC_OFS_YEAR, r);
    chk(r, yr);
    repeat (PER) @(posedge clk);
    rd(RC, r);
    chk(r & 8'hC0, 8'h40);
    $display("test reset pin done");
    summarize();
  end
endmodule
